// ### rtl/afp_cfg.svh
`ifndef AFP_CFG_SVH
`define AFP_CFG_SVH
// Frame and field layout
`define AFP_FRAME_BITS    16
`define AFP_CTRL_BITS     12
`define AFP_RES_BITS      12
`define AFP_TAG_BITS      4
`define AFP_TRACK_EDGE    5'd14
`define AFP_CTRL_EDGE     5'd12
`define AFP_LAST_EDGE     5'd16
// Control word bits, first bit on the wire is bit 11
`define AFP_C_WRITE       11
`define AFP_C_SEQ_ON      10
`define AFP_C_ADDR_HI     9
`define AFP_C_ADDR_LO     6
`define AFP_C_PM_HI       5
`define AFP_C_PM_LO       4
`define AFP_C_MASK_USE    3
`define AFP_C_WEAK        2
`define AFP_CTRL_RST      12'h030
`define AFP_MASK_RST      16'hFFFF
// Power-management field codes
`define AFP_PM_NORMAL     2'h3
`define AFP_PM_FULL_OFF   2'h2
`define AFP_PM_AUTO_SD    2'h1
`define AFP_PM_AUTO_SB    2'h0
// Idle pin levels {cs_n, sclk, din}
`define AFP_PIN_IDLE      3'h6
// Host register offsets
`define AFP_REG_TX        12'h000
`define AFP_REG_STATUS    12'h004
`define AFP_REG_RX        12'h008
`define AFP_ST_BUSY       0
`define AFP_ST_DONE       1
// Timing
`define AFP_SYS_CLK_NS    10
`define AFP_SCLK_HALF_NS  80
`define AFP_QUIET_NS      50
`define AFP_SCLK_HALF_CYC ((`AFP_SCLK_HALF_NS + `AFP_SYS_CLK_NS - 1) / `AFP_SYS_CLK_NS)
`define AFP_QUIET_CYC     ((`AFP_QUIET_NS + `AFP_SYS_CLK_NS - 1) / `AFP_SYS_CLK_NS)
`endif

// ### rtl/afp_pkg.sv
package afp_pkg;
   typedef enum logic [2:0]
   {
      FR_IDLE   = 3'b001,
      FR_ACTIVE = 3'b010,
      FR_DONE   = 3'b100
   } afp_frame_t;

   typedef enum logic [2:0]
   {
      PW_ON       = 3'b001,
      PW_STANDBY  = 3'b010,
      PW_SHUTDOWN = 3'b100
   } afp_pwr_t;

   typedef enum logic [5:0]
   {
      HS_IDLE  = 6'b000001,
      HS_LEAD  = 6'b000010,
      HS_LOW   = 6'b000100,
      HS_HIGH  = 6'b001000,
      HS_TAIL  = 6'b010000,
      HS_QUIET = 6'b100000
   } afp_host_t;
endpackage

// ### rtl/afp_link_if.sv
`timescale 1ns/10ps
interface afp_link_if;
   logic cs_n;
   logic sclk;
   logic din;
   logic dout;
   logic dout_oe;
   logic dout_weak;
   logic ext_oe;
   logic ext_val;
   wire  dout_line;

   // Strong drive, then a foreign driver, then the weak keeper
   // A floating line reads inverted, so a stale bit never passes for data
   assign dout_line = dout_oe   ? dout    :
                      ext_oe    ? ext_val :
                      dout_weak ? dout    : ~dout;

   modport device
   (
      input  cs_n,
      input  sclk,
      input  din,
      output dout,
      output dout_oe,
      output dout_weak
   );

   modport host
   (
      output cs_n,
      output sclk,
      output din,
      input  dout_line
   );
endinterface

// ### rtl/afp_device.sv
`timescale 1ns/10ps
`include "afp_cfg.svh"
module afp_device
(
   // Clock and reset
   input  wire logic                       I_SYS_CLK,
   input  wire logic                       I_RST,
   // Serial link
   afp_link_if.device                      LINK,
   // Converter core
   input  wire logic [`AFP_RES_BITS-1:0]   I_CONV_DATA,
   output logic                            O_TRACK,
   output logic                            O_CONV_START,
   output logic [`AFP_TAG_BITS-1:0]        O_CHANNEL,
   output afp_pkg::afp_pwr_t               O_PWR_STATE,
   // Register view
   output logic [`AFP_CTRL_BITS-1:0]       O_CTRL,
   output logic [`AFP_FRAME_BITS-1:0]      O_SEQ_MASK
);
   import afp_pkg::*;

   logic [2:0]                  meta_r;
   logic [2:0]                  sync_r;
   logic [2:0]                  prev_r;
   logic                        cs_fall;
   logic                        cs_rise;
   logic                        sclk_fall;
   logic                        din_s;
   afp_frame_t                  frame_r;
   logic [4:0]                  fcnt_r;
   logic [4:0]                  fcnt_nxt;
   logic                        edge_act;
   logic [`AFP_FRAME_BITS-1:0]  rx_r;
   logic [`AFP_FRAME_BITS-1:0]  rx_nxt;
   logic [`AFP_FRAME_BITS-1:0]  tx_r;
   logic [`AFP_CTRL_BITS-1:0]   ctrl_r;
   logic [`AFP_FRAME_BITS-1:0]  mask_r;
   logic                        mask_pend_r;
   logic                        mask_frame_r;
   logic [`AFP_TAG_BITS-1:0]    chan_r;
   logic [`AFP_TAG_BITS-1:0]    chan_nxt;
   logic                        dout_r;
   logic                        oe_r;
   logic                        weak_r;
   logic                        track_r;
   logic                        start_r;
   afp_pwr_t                    pwr_r;
   logic [1:0]                  pm;

   // Pins cross into the system clock; the first stage feeds only the second
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         meta_r <= `AFP_PIN_IDLE;
         sync_r <= `AFP_PIN_IDLE;
         prev_r <= `AFP_PIN_IDLE;
      end
      else
      begin
         meta_r <= {LINK.cs_n, LINK.sclk, LINK.din};
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign cs_fall   = prev_r[2] & ~sync_r[2];
   assign cs_rise   = ~prev_r[2] & sync_r[2];
   assign sclk_fall = prev_r[1] & ~sync_r[1] & ~sync_r[2];
   assign din_s     = sync_r[0];
   assign edge_act  = sclk_fall && (frame_r == FR_ACTIVE) && !cs_fall;
   assign fcnt_nxt  = fcnt_r + 5'd1;
   assign rx_nxt    = {rx_r[`AFP_FRAME_BITS-2:0], din_s};
   assign pm        = ctrl_r[`AFP_C_PM_HI:`AFP_C_PM_LO];

   // First set bit of m, scanning upward from start
   function automatic logic [3:0] first_set(input logic [15:0] m, input logic [3:0] start);
      logic [3:0] idx;
      logic [3:0] res;
      logic       hit;
      res = start;
      hit = 1'b0;
      for (int k = 0; k < 16; k++)
      begin
         idx = start + k[3:0];
         if (!hit && m[idx])
         begin
            res = idx;
            hit = 1'b1;
         end
      end
      return res;
   endfunction

   // Channel for the following conversion
   always_comb
   begin
      if (mask_frame_r)
         chan_nxt = first_set(rx_r, 4'h0);
      else if (ctrl_r[`AFP_C_SEQ_ON] && ctrl_r[`AFP_C_MASK_USE])
         chan_nxt = first_set(mask_r, chan_r + 4'h1);
      else if (ctrl_r[`AFP_C_SEQ_ON])
         chan_nxt = (chan_r >= ctrl_r[`AFP_C_ADDR_HI:`AFP_C_ADDR_LO]) ? 4'h0 : chan_r + 4'h1;
      else
         chan_nxt = ctrl_r[`AFP_C_ADDR_HI:`AFP_C_ADDR_LO];
   end

   // Frame sequencing and edge count
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         frame_r      <= FR_IDLE;
         fcnt_r       <= 5'h00;
         rx_r         <= 16'h0000;
         mask_frame_r <= 1'b0;
      end
      else if (cs_fall)
      begin
         frame_r      <= FR_ACTIVE;
         fcnt_r       <= 5'h00;
         mask_frame_r <= mask_pend_r;
      end
      else if (cs_rise)
      begin
         frame_r      <= FR_IDLE;
         mask_frame_r <= 1'b0;
      end
      else if (edge_act)
      begin
         fcnt_r <= fcnt_nxt;
         rx_r   <= rx_nxt;
         if (fcnt_nxt == `AFP_LAST_EDGE)
            frame_r <= FR_DONE;
      end
   end

   // Control word and sequence mask
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         ctrl_r      <= `AFP_CTRL_RST;
         mask_r      <= `AFP_MASK_RST;
         mask_pend_r <= 1'b0;
      end
      else if (cs_fall)
         mask_pend_r <= 1'b0;
      else if (edge_act && fcnt_nxt == `AFP_CTRL_EDGE && !mask_frame_r
               && rx_nxt[`AFP_C_WRITE])
      begin
         ctrl_r      <= rx_nxt[`AFP_CTRL_BITS-1:0];
         mask_pend_r <= ~rx_nxt[`AFP_C_SEQ_ON] & rx_nxt[`AFP_C_MASK_USE];
      end
      else if (cs_rise && mask_frame_r && frame_r == FR_DONE)
         mask_r <= rx_r;
   end

   // Output shifter, drive and keeper
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         tx_r   <= 16'h0000;
         dout_r <= 1'b0;
         oe_r   <= 1'b0;
         weak_r <= 1'b0;
         chan_r <= 4'h0;
      end
      else if (cs_fall)
      begin
         tx_r   <= {chan_r, I_CONV_DATA};
         dout_r <= chan_r[`AFP_TAG_BITS-1];
         oe_r   <= 1'b1;
         weak_r <= 1'b0;
      end
      else if (cs_rise)
      begin
         chan_r <= chan_nxt;
         dout_r <= chan_nxt[`AFP_TAG_BITS-1];
         oe_r   <= 1'b0;
         weak_r <= ctrl_r[`AFP_C_WEAK];
      end
      else if (edge_act && fcnt_nxt < `AFP_LAST_EDGE)
      begin
         tx_r   <= {tx_r[`AFP_FRAME_BITS-2:0], 1'b0};
         dout_r <= tx_r[`AFP_FRAME_BITS-2];
      end
      else if (edge_act)
      begin
         oe_r   <= 1'b0;
         weak_r <= ctrl_r[`AFP_C_WEAK];
         dout_r <= chan_nxt[`AFP_TAG_BITS-1];
      end
   end

   // Track/hold and conversion start
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         track_r <= 1'b1;
         start_r <= 1'b0;
      end
      else
      begin
         start_r <= cs_fall && pm != `AFP_PM_FULL_OFF;
         if (cs_fall)
            track_r <= 1'b0;
         else if (edge_act && fcnt_nxt == `AFP_TRACK_EDGE && !mask_frame_r)
            track_r <= 1'b1;
         else if (cs_rise && mask_frame_r)
            track_r <= 1'b1;
      end
   end

   // Power state; sleeping in full shutdown costs the next frame as wake-up
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
         pwr_r <= PW_ON;
      else if (cs_fall && pm != `AFP_PM_FULL_OFF)
         pwr_r <= PW_ON;
      else if (edge_act && fcnt_nxt == `AFP_LAST_EDGE)
      begin
         case (pm)
            `AFP_PM_AUTO_SD: pwr_r <= PW_SHUTDOWN;
            `AFP_PM_AUTO_SB: pwr_r <= PW_STANDBY;
            default:         pwr_r <= pwr_r;
         endcase
      end
      else if (cs_rise)
      begin
         case (pm)
            `AFP_PM_FULL_OFF: pwr_r <= PW_SHUTDOWN;
            `AFP_PM_NORMAL:   pwr_r <= PW_ON;
            default:          pwr_r <= pwr_r;
         endcase
      end
   end

   assign LINK.dout      = dout_r;
   assign LINK.dout_oe   = oe_r;
   assign LINK.dout_weak = weak_r;
   assign O_TRACK        = track_r;
   assign O_CONV_START   = start_r;
   assign O_CHANNEL      = chan_r;
   assign O_PWR_STATE    = pwr_r;
   assign O_CTRL         = ctrl_r;
   assign O_SEQ_MASK     = mask_r;
endmodule // afp_device

// ### rtl/afp_host.sv
`timescale 1ns/10ps
`include "afp_cfg.svh"
module afp_host
#(
   parameter int HALF_CYC  = `AFP_SCLK_HALF_CYC,
   parameter int QUIET_CYC = `AFP_QUIET_CYC
)
(
   // Clock and reset
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_RST,
   // APB slave
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [11:0] I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic      [31:0] O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   // Serial link
   afp_link_if.host         LINK
);
   import afp_pkg::*;

   afp_host_t   st_r;
   logic [7:0]  tmr_r;
   logic [4:0]  bits_r;
   logic [15:0] tx_r;
   logic [15:0] rx_sh_r;
   logic [15:0] rx_word_r;
   logic        cs_n_r;
   logic        sclk_r;
   logic        din_r;
   logic        done_r;
   logic        meta_r;
   logic        dout_s;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   logic        setup;
   logic        wr_acc;
   logic        start;
   logic        tmr_end;

   assign setup   = I_PSEL & ~I_PENABLE;
   assign wr_acc  = I_PSEL & I_PENABLE & pready_r & I_PWRITE;
   assign start   = wr_acc && I_PADDR == `AFP_REG_TX && st_r == HS_IDLE;
   assign tmr_end = tmr_r == 8'h00;

   // Returned data crosses in from the link
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         meta_r <= 1'b0;
         dout_s <= 1'b0;
      end
      else
      begin
         meta_r <= LINK.dout_line;
         dout_s <= meta_r;
      end
   end

   // Register access: zero wait states, answer on the cycle after setup
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
      end
      else
      begin
         pready_r  <= setup;
         pslverr_r <= setup && I_PADDR != `AFP_REG_TX && I_PADDR != `AFP_REG_STATUS
                      && I_PADDR != `AFP_REG_RX;
         if (setup)
         begin
            case (I_PADDR)
               `AFP_REG_TX:     prdata_r <= {16'h0000, tx_r};
               `AFP_REG_STATUS: prdata_r <= {30'h0, done_r, st_r != HS_IDLE};
               `AFP_REG_RX:     prdata_r <= {16'h0000, rx_word_r};
               default:         prdata_r <= 32'h00000000;
            endcase
         end
      end
   end

   // Done is sticky; a frame ending in the clearing cycle still sets it
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
         done_r <= 1'b0;
      else if (st_r == HS_TAIL && tmr_end)
         done_r <= 1'b1;
      else if (wr_acc && I_PADDR == `AFP_REG_STATUS && I_PWDATA[`AFP_ST_DONE])
         done_r <= 1'b0;
   end

   // Frame generator; the serial clock is divided from the system clock
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         st_r      <= HS_IDLE;
         tmr_r     <= 8'h00;
         bits_r    <= 5'h00;
         tx_r      <= 16'h0000;
         rx_sh_r   <= 16'h0000;
         rx_word_r <= 16'h0000;
         cs_n_r    <= 1'b1;
         sclk_r    <= 1'b1;
         din_r     <= 1'b0;
      end
      else
      begin
         tmr_r <= tmr_end ? 8'h00 : tmr_r - 8'h01;
         case (st_r)
            HS_IDLE:
               if (start)
               begin
                  tx_r   <= {I_PWDATA[14:0], 1'b0};
                  din_r  <= I_PWDATA[15];
                  cs_n_r <= 1'b0;
                  bits_r <= 5'h00;
                  tmr_r  <= 8'(HALF_CYC - 1);
                  st_r   <= HS_LEAD;
               end
            HS_LEAD, HS_HIGH:
               if (tmr_end)
               begin
                  sclk_r  <= 1'b0;
                  rx_sh_r <= {rx_sh_r[14:0], dout_s};
                  bits_r  <= bits_r + 5'd1;
                  tmr_r   <= 8'(HALF_CYC - 1);
                  st_r    <= HS_LOW;
               end
            HS_LOW:
               if (tmr_end)
               begin
                  sclk_r <= 1'b1;
                  tmr_r  <= 8'(HALF_CYC - 1);
                  if (bits_r == `AFP_LAST_EDGE)
                     st_r <= HS_TAIL;
                  else
                  begin
                     din_r <= tx_r[15];
                     tx_r  <= {tx_r[14:0], 1'b0};
                     st_r  <= HS_HIGH;
                  end
               end
            HS_TAIL:
               if (tmr_end)
               begin
                  cs_n_r    <= 1'b1;
                  rx_word_r <= rx_sh_r;
                  tmr_r     <= 8'(QUIET_CYC - 1);
                  st_r      <= HS_QUIET;
               end
            HS_QUIET:
               if (tmr_end)
                  st_r <= HS_IDLE;
            default:
               st_r <= HS_IDLE;
         endcase
      end
   end

   assign LINK.cs_n = cs_n_r;
   assign LINK.sclk = sclk_r;
   assign LINK.din  = din_r;
   assign O_PRDATA  = prdata_r;
   assign O_PREADY  = pready_r;
   assign O_PSLVERR = pslverr_r;
endmodule // afp_host

// ### tb/afp_link_asserts.sv
`timescale 1ns/10ps
module afp_link_asserts
(
   // Clock and reset
   input  wire logic I_SYS_CLK,
   input  wire logic I_RST,
   // Link
   input  wire logic cs_n,
   input  wire logic sclk,
   input  wire logic din,
   input  wire logic dout,
   input  wire logic dout_oe,
   input  wire logic dout_weak
);
   logic       sclk_q;
   logic       cs_q;
   logic [4:0] fall_cnt;
   logic [3:0] since_edge;
   wire        sclk_fall = sclk_q && !sclk;
   wire        cs_fall   = cs_q && !cs_n;

   always_ff @(posedge I_SYS_CLK or posedge I_RST)
      if (I_RST)
      begin
         sclk_q <= 1'b1;
         cs_q   <= 1'b1;
      end
      else
      begin
         sclk_q <= sclk;
         cs_q   <= cs_n;
      end
   // Counted at the pins, so it leads the device's synchronised view
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
      if (I_RST)
         fall_cnt <= 5'h0;
      else if (cs_fall)
         fall_cnt <= 5'h0;
      else if (sclk_fall && !cs_n)
         fall_cnt <= fall_cnt + 5'h1;
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
      if (I_RST)
         since_edge <= 4'hF;
      else if (sclk_fall || cs_q != cs_n)
         since_edge <= 4'h0;
      else if (since_edge != 4'hF)
         since_edge <= since_edge + 4'h1;

   default clocking dc @(posedge I_SYS_CLK);
   endclocking
   default disable iff (I_RST);

   AST_OE_ON_SELECT: assert property (cs_fall |-> ##[1:8] dout_oe)
      else $error("output not driven after select fall");
   AST_FRAME_SIXTEEN: assert property ((!cs_q && cs_n) |-> fall_cnt == 5'd16)
      else $error("frame ended without sixteen clock falls");
   AST_OE_HOLDS: assert property ((!cs_n && dout_oe && fall_cnt < 5'd16) |=> dout_oe)
      else $error("output released before the last bit");
   AST_OE_OFF_SIXTEENTH: assert property ((sclk_fall && !cs_n && fall_cnt == 5'd15)
      |-> ##[1:8] !dout_oe)
      else $error("output still driven after sixteenth fall");
   AST_DOUT_ON_EDGE: assert property ((dout_oe && $changed(dout)) |-> since_edge <= 4'd7)
      else $error("driven data changed away from a clock fall");
   AST_WEAK_NOT_STRONG: assert property (dout_weak |-> !dout_oe)
      else $error("keeper and strong drive both on");
   AST_IDLE_FLOAT: assert property ((cs_n && since_edge == 4'hF) |-> !dout_oe)
      else $error("strong drive between frames");
   AST_DIN_STEADY: assert property ((sclk_fall && !cs_n) |-> $stable(din))
      else $error("serial input moved at a clock fall");

   COV_FRAME: cover property (!cs_q && cs_n && fall_cnt == 5'd16);
   COV_WEAK: cover property ($rose(dout_weak));
   COV_LAST_FALL: cover property (sclk_fall && fall_cnt == 5'd15);
endmodule // afp_link_asserts

// ### tb/test_adc_serial_frame_port.sv
`timescale 1ns/10ps
`include "afp_cfg.svh"
module test_adc_serial_frame_port;
   import afp_pkg::*;
   logic        sys_clk;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [11:0] conv_data;
   logic        track;
   afp_pwr_t    pwr_state;
   logic [11:0] ctrl;
   logic [15:0] seq_mask;
   logic [3:0]  channel;
   logic        conv_start;
   logic [31:0] rd;
   logic        err;
   logic [15:0] w;
   int          n_errors;
   int          total_checks;
   int          m_chan;
   bit          m_known;
   bit          m_mask_next;
   logic [11:0] m_ctrl;
   logic [15:0] m_mask;
   int          n_start;
   afp_pwr_t    pw_exp [4];
   int          pm_seq [4];

   afp_link_if link();

   afp_host u_afp_host
   (
      .I_SYS_CLK (sys_clk),
      .I_RST     (rst),
      .I_PSEL    (psel),
      .I_PENABLE (penable),
      .I_PWRITE  (pwrite),
      .I_PADDR   (paddr),
      .I_PWDATA  (pwdata),
      .O_PRDATA  (prdata),
      .O_PREADY  (pready),
      .O_PSLVERR (pslverr),
      .LINK      (link)
   );
   afp_device u_afp_device
   (
      .I_SYS_CLK    (sys_clk),
      .I_RST        (rst),
      .LINK         (link),
      .I_CONV_DATA  (conv_data),
      .O_TRACK      (track),
      .O_CONV_START (conv_start),
      .O_CHANNEL    (channel),
      .O_PWR_STATE  (pwr_state),
      .O_CTRL       (ctrl),
      .O_SEQ_MASK   (seq_mask)
   );
   afp_link_asserts u_afp_link_asserts
   (
      .I_SYS_CLK (sys_clk),
      .I_RST     (rst),
      .cs_n      (link.cs_n),
      .sclk      (link.sclk),
      .din       (link.din),
      .dout      (link.dout),
      .dout_oe   (link.dout_oe),
      .dout_weak (link.dout_weak)
   );

   task automatic summarize();
      if (n_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1)
         @(posedge sys_clk);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   function automatic int m_step(input int c);
      int n;
      n = c;
      if (m_ctrl[10] && m_ctrl[3])
      begin
         for (int k = 16; k >= 1; k--)
            if (m_mask[(c + k) % 16])
               n = (c + k) % 16;
      end
      else if (m_ctrl[10])
         n = (c >= m_ctrl[9:6]) ? 0 : c + 1;
      else
         n = m_ctrl[9:6];
      return n;
   endfunction

   always @(posedge sys_clk)
      if (conv_start === 1'b1)
         n_start++;

   task automatic frame(input logic [15:0] fw, input bit tag_ok);
      logic [11:0] cd;
      int          n;
      int          s0;
      bit          exp_s;
      cd    = 12'($urandom);
      s0    = n_start;
      exp_s = m_ctrl[5:4] != `AFP_PM_FULL_OFF;
      conv_data <= cd;
      apb(1'b1, `AFP_REG_TX, {16'h0, fw});
      n  = 0;
      rd = 32'h0;
      // Busy must be clear as well, or the next TX write is dropped
      while ((rd[1] !== 1'b1 || rd[0] !== 1'b0) && n < 400)
      begin
         apb(1'b0, `AFP_REG_STATUS, 32'h0);
         n++;
      end
      apb(1'b0, `AFP_REG_RX, 32'h0);
      if (tag_ok && m_known)
         chk("rx word", {16'h0, m_chan[3:0], cd}, rd);
      else
         chk("rx result", {20'h0, cd}, {20'h0, rd[11:0]});
      apb(1'b1, `AFP_REG_STATUS, 32'h2);
      if (m_mask_next)
      begin
         chk("mask", {16'h0, fw}, {16'h0, seq_mask});
         chk("track", 32'h1, {31'h0, track});
         m_mask_next = 1'b0;
         m_mask      = fw;
         m_chan      = 0;
         for (int k = 15; k >= 0; k--)
            if (fw[k])
               m_chan = k;
      end
      else
      begin
         if (fw[15])
         begin
            m_ctrl      = fw[15:4];
            m_mask_next = !fw[14] && fw[7];
         end
         m_chan = m_step(m_chan);
      end
      chk("ctrl", {20'h0, m_ctrl}, {20'h0, ctrl});
      chk("channel", m_chan, {28'h0, channel});
      chk("start pulses", {31'h0, exp_s}, n_start - s0);
   endtask

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial
   begin
      #600000;
      n_errors++;
      summarize();
   end

   initial
   begin
      n_errors     = 0;
      total_checks = 0;
      rst          = 1'b1;
      psel         = 1'b0;
      penable      = 1'b0;
      pwrite       = 1'b0;
      paddr        = 12'h0;
      pwdata       = 32'h0;
      conv_data    = 12'h0;
      link.ext_oe  = 1'b0;
      link.ext_val = 1'b0;
      m_chan       = 0;
      m_known      = 1'b1;
      m_mask_next  = 1'b0;
      m_ctrl       = `AFP_CTRL_RST;
      m_mask       = `AFP_MASK_RST;
      n_start      = 0;
      pw_exp       = '{PW_STANDBY, PW_SHUTDOWN, PW_SHUTDOWN, PW_ON};
      pm_seq       = '{1, 0, 2, 3};
      void'($urandom(44687));
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chk("mask reset", 32'hFFFF, {16'h0, seq_mask});
      apb(1'b0, 12'hFFC, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      for (int i = 0; i < 8; i++)
      begin
         w = {1'($urandom), 1'b0, 4'($urandom), 2'b11, 1'b0, 1'($urandom), 6'h0};
         frame(w, 1'b1);
         chk("track", 32'h1, {31'h0, track});
         if (m_ctrl[2])
         begin
            chk("held line", {31'h0, m_chan[3]}, {31'h0, link.dout_line});
            link.ext_val <= !m_chan[3];
            link.ext_oe  <= 1'b1;
            repeat (2) @(posedge sys_clk);
            chk("taken line", {31'h0, !m_chan[3]}, {31'h0, link.dout_line});
            link.ext_oe <= 1'b0;
            @(posedge sys_clk);
         end
         else
            chk("float line", {31'h0, !m_chan[3]}, {31'h0, link.dout_line});
      end
      frame({1'b1, 1'b0, 4'h2, 2'b11, 1'b1, 7'h0}, 1'b1);
      frame(16'($urandom) | 16'h0010, 1'b1);
      frame({1'b1, 1'b0, 4'h9, 2'b11, 8'h0}, 1'b1);
      frame({1'b1, 1'b1, 4'h0, 2'b11, 1'b1, 7'h0}, 1'b1);
      repeat (3) frame(16'h0000, 1'b1);
      frame({1'b1, 1'b1, 4'h2, 2'b11, 8'h0}, 1'b1);
      repeat (3) frame(16'h0000, 1'b1);
      for (int i = 0; i < 4; i++)
      begin
         frame({1'b1, 1'b0, 4'h3, pm_seq[i][1:0], 8'h0}, 1'b1);
         chk("power", {29'h0, pw_exp[pm_seq[i]]}, {29'h0, pwr_state});
         if (pm_seq[i] < 2)
         begin
            frame(16'h0FF0, 1'b1);
            chk("power", {29'h0, pw_exp[pm_seq[i]]}, {29'h0, pwr_state});
         end
      end
      summarize();
   end
endmodule // test_adc_serial_frame_port
